//--- bench/ccpp_chk.sv
// Port checker for the charge sequencer.
// Assumes one clock domain and asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ccpp_chk
import ccpp_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic cell_pin_low_in,
	input wire logic charge_current_set_lo_in,
	input wire logic supply_above_batt_in,
	input wire logic undervoltage_lockout_in,
	input wire logic input_overvoltage_in,
	input wire logic [1:0] cell_sel_out,
	input wire logic charge_enable_out,
	input wire logic precharge_current_out,
	input wire logic fast_charge_out,
	input wire logic ref_enable_out,
	input wire logic status_oe_n_out,
	input wire logic adapter_switch_drive_out,
	input wire logic battery_switch_drive_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	logic [11:0] off_cnt;
	// Consecutive cycles with both switches off
	always_ff @(posedge clk_in or negedge arst_n_in)
		if (!arst_n_in)
			off_cnt <= 12'h000;
		else if (adapter_switch_drive_out || battery_switch_drive_out)
			off_cnt <= 12'h000;
		else if (off_cnt != 12'hFFF)
			off_cnt <= off_cnt + 12'h001;
	excl_sw_a: assert property (!(adapter_switch_drive_out && battery_switch_drive_out))
		else $error("both switches on");
	dead_time_a: assert property ($rose(adapter_switch_drive_out) |-> off_cnt >= DEAD_CYC - 12'h001)
		else $error("dead time short");
	sleep_out_a: assert property (!supply_above_batt_in [*7] |-> status_oe_n_out && !ref_enable_out && !adapter_switch_drive_out)
		else $error("sleep outputs wrong");
	undervoltage_lockout_off_a: assert property (undervoltage_lockout_in [*7] |-> !charge_enable_out && !adapter_switch_drive_out && !battery_switch_drive_out)
		else $error("lockout not honoured");
	charge_current_set_off_a: assert property (charge_current_set_lo_in [*7] |-> !charge_enable_out)
		else $error("charge with set low");
	input_bad_a: assert property (input_overvoltage_in [*7] |-> !charge_enable_out && !adapter_switch_drive_out)
		else $error("bad input not honoured");
	one_cell_a: assert property (cell_pin_low_in [*7] |-> cell_sel_out == CELL_ONE)
		else $error("cell select wrong");
	one_phase_a: assert property (charge_enable_out |-> precharge_current_out ^ fast_charge_out)
		else $error("charge phase wrong");
endmodule
bind ccpp_top ccpp_chk ccpp_chk_inst (.*);
`default_nettype wire

//--- bench/ccpp_pack_model.sv
// Adapter and battery pack model driving the supply comparator flags.
// Assumes the bench plugs the adapter and sets the battery level.
`timescale 1ns/1ps
`default_nettype none
module ccpp_pack_model
#(
	parameter int RISE = 0
)
(
	input wire logic clk_in,
	input wire logic plug_in,
	input wire logic batt_low_in,
	output logic supply_above_batt_out,
	output logic supply_above_300_out,
	output logic neg_below_200_out,
	output logic batt_below_low_out
);
	int rise_cnt = 0;
	// Margin over battery builds up after plug-in
	always_ff @(posedge clk_in)
		rise_cnt <= plug_in ? (rise_cnt < RISE ? rise_cnt + 1 : rise_cnt) : 0;
	assign supply_above_batt_out = plug_in;
	assign supply_above_300_out = plug_in && rise_cnt >= RISE;
	assign neg_below_200_out = !plug_in;
	assign batt_below_low_out = batt_low_in;
endmodule
`default_nettype wire

//--- bench/ccpp_top_tb.sv
// Self-checking bench for the charge sequencer with a pack model.
// Assumes short timer parameters and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module ccpp_top_tb;
	import ccpp_pkg::*;
	logic clk_in, arst_n_in, cell_pin_low_in, cell_pin_high_in, charge_current_set_hi_in;
	logic charge_current_set_lo_in, battery_below_low_in, battery_below_recharge_in;
	logic current_below_term_in, voltage_reg_phase_in, timer_capacitor_gnd_in;
	logic timer_capacitor_ref_in, supply_above_batt_in, supply_above_batt_300_in;
	logic undervoltage_lockout_in, input_overvoltage_in, input_undervoltage_in;
	logic regulators_good_in, thermal_shutdown_in, thermistor_fault_in;
	logic input_neg_below_batt_200_in, reg_wr_in, reg_rd_in, plug, blow, inhibit;
	logic [7:0] reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, d;
	logic [1:0] cell_sel_out;
	logic charge_enable_out, precharge_current_out, fast_charge_out, charge_done_out;
	logic fault_out, ref_enable_out, status_out, status_oe_n_out;
	logic adapter_switch_drive_out, battery_switch_drive_out;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	localparam int RISE = 100;
	ccpp_top #(.PHASE_DEG(44'h14), .POWERUP_DLY(44'h32), .PRECHG_TMO(44'hC8),
		.FASTCHG_TMO(44'h190)) ccpp_top_inst (.*);
	ccpp_pack_model #(.RISE(RISE)) ccpp_pack_model_inst (.clk_in(clk_in), .plug_in(plug),
		.batt_low_in(blow),
		.supply_above_batt_out(supply_above_batt_in), .supply_above_300_out(supply_above_batt_300_in),
		.neg_below_200_out(input_neg_below_batt_200_in), .batt_below_low_out(battery_below_low_in));
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc > 30000)
		begin
			err_count++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	// Reference model of the charge enable terms
	function automatic logic model_en();
		return charge_current_set_hi_in && !undervoltage_lockout_in && plug && !inhibit
			&& !input_overvoltage_in && !input_undervoltage_in && regulators_good_in
			&& !thermal_shutdown_in && !thermistor_fault_in;
	endfunction
	task automatic stop_cond(input int k, input logic v);
		@(posedge clk_in);
		case (k)
			0: thermal_shutdown_in <= v;
			1: thermistor_fault_in <= v;
			2: input_overvoltage_in <= v;
			3: input_undervoltage_in <= v;
			4: regulators_good_in <= !v;
			default:
			begin
				charge_current_set_lo_in <= v;
				charge_current_set_hi_in <= !v;
			end
		endcase
	endtask
	task automatic toggle_charge_current_set();
		stop_cond(5, 1'b1);
		tick(10);
		stop_cond(5, 1'b0);
	endtask
	initial
	begin
		{cell_pin_low_in, cell_pin_high_in, charge_current_set_lo_in, battery_below_recharge_in,
			current_below_term_in, voltage_reg_phase_in, timer_capacitor_gnd_in,
			undervoltage_lockout_in, input_overvoltage_in, input_undervoltage_in,
			thermal_shutdown_in, thermistor_fault_in, reg_wr_in, reg_rd_in, plug, blow,
			inhibit, arst_n_in} = '0;
		{charge_current_set_hi_in, regulators_good_in, timer_capacitor_ref_in} = 3'h7;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		void'($urandom(32'hC13D5067));
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'b1;
		tick(10);
		chk("cell_sel", cell_sel_out, 32'h2);
		chk("status_oe_n", status_oe_n_out, 32'h1);
		chk("bat_drv", battery_switch_drive_out, 32'h1);
		chk("ac_drv", adapter_switch_drive_out, 32'h0);
		rd(ADDR_CTRL);
		chk("ctrl", d, CTRL_RESET);
		rd(8'h08);
		chk("unmapped", d, 32'h0);
		wr(ADDR_CTRL, $urandom() & 32'hFFFF_FFFE);
		rd(ADDR_CTRL);
		chk("inhibit", d[0], 32'h0);
		rd(ADDR_STATUS);
		chk("state", d[4:0], CH_IDLE);
		tick(1);
		chk("rdata idle", reg_rdata_out, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk_in);
			cell_pin_low_in <= (i == 0);
			cell_pin_high_in <= (i == 2);
			tick(10);
			chk("cell_sel", cell_sel_out, i + 1);
		end
		@(posedge clk_in);
		cell_pin_high_in <= 1'b0;
		plug <= 1'b1;
		n = 0;
		while (battery_switch_drive_out === 1'b1 && n < 50)
		begin
			tick(1);
			n++;
		end
		chk("ac_drv", adapter_switch_drive_out, 32'h0);
		n = 0;
		while (adapter_switch_drive_out !== 1'b1 && n < 3000)
		begin
			tick(1);
			n++;
		end
		chk("dead", n, 32'(DEAD_CYC) + RISE);
		tick(10);
		chk("en", charge_enable_out, model_en());
		chk("fast", fast_charge_out, 32'h1);
		chk("status", {status_out, status_oe_n_out, ref_enable_out}, 32'h5);
		$display("changeover test done");
		for (int k = 0; k < 6; k++)
		begin
			stop_cond(k, 1'b1);
			tick(12);
			chk("en", charge_enable_out, model_en());
			chk("ac_drv", adapter_switch_drive_out, !(k == 2 || k == 3));
			stop_cond(k, 1'b0);
			tick(2100);
			chk("en", charge_enable_out, model_en());
		end
		inhibit = 1'b1;
		wr(ADDR_CTRL, 32'h1);
		tick(10);
		chk("en", charge_enable_out, model_en());
		inhibit = 1'b0;
		wr(ADDR_CTRL, 32'h0);
		tick(10);
		chk("en", charge_enable_out, model_en());
		$display("stop test done");
		@(posedge clk_in);
		voltage_reg_phase_in <= 1'b1;
		current_below_term_in <= 1'b1;
		timer_capacitor_gnd_in <= 1'b1;
		tick(12);
		chk("done", {charge_done_out, charge_enable_out}, 32'h1);
		@(posedge clk_in);
		timer_capacitor_gnd_in <= 1'b0;
		tick(12);
		chk("done", {charge_done_out, charge_enable_out}, 32'h2);
		@(posedge clk_in);
		battery_below_recharge_in <= 1'b1;
		voltage_reg_phase_in <= 1'b0;
		current_below_term_in <= 1'b0;
		tick(12);
		chk("en", charge_enable_out, 32'h1);
		@(posedge clk_in);
		battery_below_recharge_in <= 1'b0;
		timer_capacitor_ref_in <= 1'b0;
		tick(450);
		chk("en", charge_enable_out, 32'h0);
		@(posedge clk_in);
		timer_capacitor_ref_in <= 1'b1;
		toggle_charge_current_set();
		tick(40);
		chk("en", charge_enable_out, 32'h1);
		$display("termination test done");
		@(posedge clk_in);
		blow <= 1'b1;
		tick(12);
		chk("pre", precharge_current_out, 32'h0);
		tick(30);
		chk("pre", {precharge_current_out, fast_charge_out}, 32'h2);
		tick(230);
		chk("fault", {fault_out, charge_enable_out}, 32'h2);
		@(posedge clk_in);
		blow <= 1'b0;
		toggle_charge_current_set();
		tick(40);
		chk("fault", {fault_out, fast_charge_out}, 32'h1);
		@(posedge clk_in);
		blow <= 1'b1;
		toggle_charge_current_set();
		tick(12);
		chk("pre", {precharge_current_out, fast_charge_out}, 32'h2);
		$display("precharge test done");
		@(posedge clk_in);
		plug <= 1'b0;
		tick(12);
		chk("sleep", {adapter_switch_drive_out, battery_switch_drive_out}, 32'h1);
		chk("sleep", {status_oe_n_out, ref_enable_out, charge_enable_out}, 32'h4);
		@(posedge clk_in);
		undervoltage_lockout_in <= 1'b1;
		tick(12);
		chk("undervoltage_lockout", {battery_switch_drive_out, charge_enable_out}, 32'h0);
		$display("sleep test done");
		end_of_test();
	end
endmodule
`default_nettype wire

//--- logic/ccpp_pkg.sv
// Constants, field positions and state types for the charge sequencer.
// Assumes a 200 MHz core clock; all intervals are derived from it.
package ccpp_pkg;
	localparam longint CLK_HZ = 200_000_000;
	// Deglitch between fast charge and pre-charge
	localparam longint PHASE_DEG_MS = 25;
	localparam logic [43:0] PHASE_DEG_CYC = 44'(PHASE_DEG_MS * CLK_HZ / 1000);
	// Delay after power-up before charge may start
	localparam longint POWERUP_MS = 1500;
	localparam logic [43:0] POWERUP_CYC = 44'(POWERUP_MS * CLK_HZ / 1000);
	// Pre-charge safety time
	localparam longint PRECHG_MIN = 30;
	localparam logic [43:0] PRECHG_CYC = 44'(PRECHG_MIN * 60 * CLK_HZ);
	// Fast charge safety time, set by the timer capacitor; plain default
	localparam longint FASTCHG_MIN = 300;
	localparam logic [43:0] FASTCHG_CYC = 44'(FASTCHG_MIN * 60 * CLK_HZ);
	// Break-before-make dead time
	localparam longint DEAD_NS = 10_000;
	localparam logic [11:0] DEAD_CYC = 12'(DEAD_NS * CLK_HZ / 1_000_000_000);
	// Synchronised comparator flag positions
	localparam int SYNC_W = 19;
	localparam int IN_CELL_LOW = 0;
	localparam int IN_CELL_HIGH = 1;
	localparam int IN_CHARGE_CURRENT_SET_HI = 2;
	localparam int IN_CHARGE_CURRENT_SET_LO = 3;
	localparam int IN_BATT_LOW = 4;
	localparam int IN_BATT_RECH = 5;
	localparam int IN_CUR_TERM = 6;
	localparam int IN_VREG = 7;
	localparam int IN_TTC_GND = 8;
	localparam int IN_TTC_REF = 9;
	localparam int IN_SUP_BATT = 10;
	localparam int IN_SUP_300 = 11;
	localparam int IN_UNDERVOLTAGE_LOCKOUT = 12;
	localparam int IN_OV = 13;
	localparam int IN_UV = 14;
	localparam int IN_REG_GOOD = 15;
	localparam int IN_THERMAL_SHUTDOWN = 16;
	localparam int IN_TS_FAULT = 17;
	localparam int IN_ACN_200 = 18;
	// Register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_INHIBIT_BIT = 0;
	// Cell count codes on the regulation target output
	localparam logic [1:0] CELL_ONE = 2'h1;
	localparam logic [1:0] CELL_TWO = 2'h2;
	localparam logic [1:0] CELL_THREE = 2'h3;
	typedef enum logic [4:0] {
		CH_IDLE = 5'h01,
		CH_PRE = 5'h02,
		CH_FAST = 5'h04,
		CH_DONE = 5'h08,
		CH_FAULT = 5'h10
	} ccpp_chg_t;
	typedef enum logic [2:0] {
		PP_BATT = 3'h1,
		PP_DEAD = 3'h2,
		PP_ADAPT = 3'h4
	} ccpp_path_t;
endpackage

//--- logic/ccpp_sync.sv
// Three-stage synchroniser for the comparator flags.
// Assumes asynchronous flags; a change is taken once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ccpp_sync
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [ccpp_pkg::SYNC_W-1:0] raw_in,
	output logic [ccpp_pkg::SYNC_W-1:0] flag_out
);
	import ccpp_pkg::*;
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		logic [SYNC_W-1:0] q;
	} ccpp_sync_st_t;
	ccpp_sync_st_t st;
	ccpp_sync_st_t next_st;
	always_comb
	begin
		next_st.s1 = raw_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.q = st.q;
		for (int i = 0; i < SYNC_W; i++)
		begin
			if (st.s2[i] == st.s3[i])
			begin
				next_st.q[i] = st.s3[i];
			end
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end
	assign flag_out = st.q;
endmodule
`default_nettype wire

//--- logic/ccpp_top.sv
// Charge cycle sequencer and power path selector of a stand-alone charger.
// Assumes comparator flags from the analog front end and a 200 MHz clock.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ccpp_top
#(
	parameter logic [43:0] PHASE_DEG = ccpp_pkg::PHASE_DEG_CYC,
	parameter logic [43:0] POWERUP_DLY = ccpp_pkg::POWERUP_CYC,
	parameter logic [43:0] PRECHG_TMO = ccpp_pkg::PRECHG_CYC,
	parameter logic [43:0] FASTCHG_TMO = ccpp_pkg::FASTCHG_CYC
)
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic cell_pin_low_in,
	input wire logic cell_pin_high_in,
	input wire logic charge_current_set_hi_in,
	input wire logic charge_current_set_lo_in,
	input wire logic battery_below_low_in,
	input wire logic battery_below_recharge_in,
	input wire logic current_below_term_in,
	input wire logic voltage_reg_phase_in,
	input wire logic timer_capacitor_gnd_in,
	input wire logic timer_capacitor_ref_in,
	input wire logic supply_above_batt_in,
	input wire logic supply_above_batt_300_in,
	input wire logic undervoltage_lockout_in,
	input wire logic input_overvoltage_in,
	input wire logic input_undervoltage_in,
	input wire logic regulators_good_in,
	input wire logic thermal_shutdown_in,
	input wire logic thermistor_fault_in,
	input wire logic input_neg_below_batt_200_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic [1:0] cell_sel_out,
	output logic charge_enable_out,
	output logic precharge_current_out,
	output logic fast_charge_out,
	output logic charge_done_out,
	output logic fault_out,
	output logic ref_enable_out,
	output logic status_out,
	output logic status_oe_n_out,
	output logic adapter_switch_drive_out,
	output logic battery_switch_drive_out
);
	import ccpp_pkg::*;
	typedef struct packed {
		ccpp_chg_t chg;
		ccpp_path_t path;
		logic charge_current_set_en;
		logic ctrl_inhibit;
		logic [43:0] pu_cnt;
		logic [43:0] tmr;
		logic [43:0] deg;
		logic [11:0] dead;
		logic [31:0] rdata;
		logic [1:0] cell_sel;
		logic chg_en;
		logic pre_sel;
		logic fast;
		logic done;
		logic fault;
		logic ref_en;
		logic stat;
		logic stat_oe_n;
		logic ac_drv;
		logic bat_drv;
	} ccpp_st_t;
	ccpp_st_t st;
	ccpp_st_t next_st;
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] f;
	logic sleep;
	logic undervoltage_lockout;
	logic qualified;
	logic pu_done;
	logic enable_ok;
	logic charge_current_set_rise;
	logic term_en;
	logic fast_tmr_en;
	always_comb
	begin
		raw = '0;
		raw[IN_CELL_LOW] = cell_pin_low_in;
		raw[IN_CELL_HIGH] = cell_pin_high_in;
		raw[IN_CHARGE_CURRENT_SET_HI] = charge_current_set_hi_in;
		raw[IN_CHARGE_CURRENT_SET_LO] = charge_current_set_lo_in;
		raw[IN_BATT_LOW] = battery_below_low_in;
		raw[IN_BATT_RECH] = battery_below_recharge_in;
		raw[IN_CUR_TERM] = current_below_term_in;
		raw[IN_VREG] = voltage_reg_phase_in;
		raw[IN_TTC_GND] = timer_capacitor_gnd_in;
		raw[IN_TTC_REF] = timer_capacitor_ref_in;
		raw[IN_SUP_BATT] = supply_above_batt_in;
		raw[IN_SUP_300] = supply_above_batt_300_in;
		raw[IN_UNDERVOLTAGE_LOCKOUT] = undervoltage_lockout_in;
		raw[IN_OV] = input_overvoltage_in;
		raw[IN_UV] = input_undervoltage_in;
		raw[IN_REG_GOOD] = regulators_good_in;
		raw[IN_THERMAL_SHUTDOWN] = thermal_shutdown_in;
		raw[IN_TS_FAULT] = thermistor_fault_in;
		raw[IN_ACN_200] = input_neg_below_batt_200_in;
	end
	// Comparator flags into the clock domain
	ccpp_sync u_sync
	(
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.raw_in(raw),
		.flag_out(f)
	);
	always_comb
	begin
		next_st = st;
		undervoltage_lockout = f[IN_UNDERVOLTAGE_LOCKOUT];
		sleep = !f[IN_SUP_BATT];
		qualified = !f[IN_OV] && !f[IN_UV];
		pu_done = (st.pu_cnt == POWERUP_DLY);
		term_en = !f[IN_TTC_GND];
		fast_tmr_en = !f[IN_TTC_GND] && !f[IN_TTC_REF];
		// Current-set hysteresis
		if (f[IN_CHARGE_CURRENT_SET_LO])
		begin
			next_st.charge_current_set_en = 1'b0;
		end
		else if (f[IN_CHARGE_CURRENT_SET_HI])
		begin
			next_st.charge_current_set_en = 1'b1;
		end
		charge_current_set_rise = next_st.charge_current_set_en && !st.charge_current_set_en;
		// Power-up delay counts once from reset
		if (!pu_done)
		begin
			next_st.pu_cnt = st.pu_cnt + 44'h1;
		end
		// Cell count select
		if (f[IN_CELL_LOW])
		begin
			next_st.cell_sel = CELL_ONE;
		end
		else if (f[IN_CELL_HIGH])
		begin
			next_st.cell_sel = CELL_THREE;
		end
		else
		begin
			next_st.cell_sel = CELL_TWO;
		end
		enable_ok = st.charge_current_set_en && !undervoltage_lockout && !sleep && qualified && pu_done
			&& f[IN_REG_GOOD] && !f[IN_THERMAL_SHUTDOWN] && !f[IN_TS_FAULT] && st.ac_drv
			&& !st.ctrl_inhibit;
		// Power path selector
		case (st.path)
			PP_BATT:
			begin
				next_st.dead = '0;
				if (!undervoltage_lockout && !sleep && qualified && f[IN_SUP_300])
				begin
					next_st.path = PP_DEAD;
				end
			end
			PP_DEAD:
			begin
				next_st.dead = st.dead + 12'h1;
				if (undervoltage_lockout || sleep || !qualified || !f[IN_SUP_300])
				begin
					next_st.path = PP_BATT;
				end
				else if (st.dead == DEAD_CYC - 12'h1)
				begin
					next_st.path = PP_ADAPT;
				end
			end
			PP_ADAPT:
			begin
				if (undervoltage_lockout || sleep || !qualified)
				begin
					next_st.path = PP_BATT;
				end
			end
			default:
			begin
				next_st.path = PP_BATT;
			end
		endcase
		next_st.ac_drv = (next_st.path == PP_ADAPT);
		next_st.bat_drv = (next_st.path == PP_BATT) && !undervoltage_lockout && f[IN_ACN_200];
		// Charge sequencer
		case (st.chg)
			CH_IDLE:
			begin
				next_st.tmr = '0;
				next_st.deg = '0;
				if (enable_ok)
				begin
					next_st.chg = f[IN_BATT_LOW] ? CH_PRE : CH_FAST;
				end
			end
			CH_PRE:
			begin
				next_st.tmr = st.tmr + 44'h1;
				next_st.deg = f[IN_BATT_LOW] ? 44'h0 : st.deg + 44'h1;
				if (!enable_ok)
				begin
					next_st.chg = CH_IDLE;
				end
				else if (st.tmr == PRECHG_TMO - 44'h1)
				begin
					next_st.chg = CH_FAULT;
				end
				else if (st.deg == PHASE_DEG - 44'h1)
				begin
					next_st.chg = CH_FAST;
					next_st.tmr = '0;
					next_st.deg = '0;
				end
			end
			CH_FAST:
			begin
				next_st.tmr = fast_tmr_en ? st.tmr + 44'h1 : 44'h0;
				next_st.deg = f[IN_BATT_LOW] ? st.deg + 44'h1 : 44'h0;
				if (!enable_ok)
				begin
					next_st.chg = CH_IDLE;
				end
				else if (fast_tmr_en && st.tmr == FASTCHG_TMO - 44'h1)
				begin
					next_st.chg = CH_FAULT;
				end
				else if (term_en && f[IN_VREG] && !f[IN_BATT_RECH] && f[IN_CUR_TERM])
				begin
					next_st.chg = CH_DONE;
				end
				else if (st.deg == PHASE_DEG - 44'h1)
				begin
					next_st.chg = CH_PRE;
					next_st.tmr = '0;
					next_st.deg = '0;
				end
			end
			CH_DONE:
			begin
				if (!enable_ok || f[IN_BATT_RECH])
				begin
					next_st.chg = CH_IDLE;
				end
			end
			CH_FAULT:
			begin
				if (charge_current_set_rise || undervoltage_lockout)
				begin
					next_st.chg = CH_IDLE;
				end
			end
			default:
			begin
				next_st.chg = CH_IDLE;
			end
		endcase
		if (undervoltage_lockout && st.chg != CH_FAULT)
		begin
			next_st.chg = CH_IDLE;
		end
		next_st.chg_en = (next_st.chg == CH_PRE) || (next_st.chg == CH_FAST);
		next_st.pre_sel = (next_st.chg == CH_PRE);
		next_st.fast = (next_st.chg == CH_FAST);
		next_st.done = (next_st.chg == CH_DONE);
		next_st.fault = (next_st.chg == CH_FAULT);
		next_st.ref_en = !sleep && !undervoltage_lockout;
		next_st.stat = next_st.chg_en;
		next_st.stat_oe_n = sleep || undervoltage_lockout;
		// Register port
		if (reg_wr_in && reg_addr_in == ADDR_CTRL)
		begin
			next_st.ctrl_inhibit = reg_wdata_in[CTRL_INHIBIT_BIT];
		end
		next_st.rdata = '0;
		if (reg_rd_in && reg_addr_in == ADDR_CTRL)
		begin
			next_st.rdata[CTRL_INHIBIT_BIT] = st.ctrl_inhibit;
		end
		else if (reg_rd_in && reg_addr_in == ADDR_STATUS)
		begin
			next_st.rdata[12:0] = {st.cell_sel, st.charge_current_set_en, pu_done, sleep, undervoltage_lockout,
				st.bat_drv, st.ac_drv, st.chg};
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st <= '0;
			st.chg <= CH_IDLE;
			st.path <= PP_BATT;
			st.ctrl_inhibit <= CTRL_RESET[CTRL_INHIBIT_BIT];
			st.cell_sel <= CELL_TWO;
			st.stat_oe_n <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end
	assign reg_rdata_out = st.rdata;
	assign cell_sel_out = st.cell_sel;
	assign charge_enable_out = st.chg_en;
	assign precharge_current_out = st.pre_sel;
	assign fast_charge_out = st.fast;
	assign charge_done_out = st.done;
	assign fault_out = st.fault;
	assign ref_enable_out = st.ref_en;
	assign status_out = st.stat;
	assign status_oe_n_out = st.stat_oe_n;
	assign adapter_switch_drive_out = st.ac_drv;
	assign battery_switch_drive_out = st.bat_drv;
endmodule
`default_nettype wire
